// ---- hdl/ccpoc_port_ctrl.sv ----
// output decision logic of a reversible-connector port controller, with apb status/control
// assumes converter samples and pin levels arrive synchronous to I_CORE_CLK; no debounce here
// Notes on behaviour
// - source vbus enable only while sink attached
// - orientation high when idle or cc1 sink
// - orientation low when sink on cc2 but not on cc1
// - source powers cc1 cable electronics, active low
// - source powers cc2 cable electronics, active low
// - source flags audio adapter on connector
// - overcurrent sets sticky fault indicator
// - fault cleared only by enable toggle/reset
// - sink attach needs cc connection and vbus
// - sink default current indicator pulled low
// - sink medium current indicator pulled low
// - sink high current indicator pulled low
// - classify both cc lines every cycle
// - fault input forces all outputs except the fault indicator inactive
// - outputs except the fault indicator inactive unless enable held high
// - strap at reset picks mode; sink sticks
// - vbus overvoltage also latches the fault
module ccpoc_port_ctrl
	import ccpoc_pkg::*;
(
	input  wire logic              I_CORE_CLK,
	input  wire logic              I_RESET,
	input  wire logic              I_ENABLE,
	input  wire logic              I_OVERCURRENT_IN_N,
	input  wire logic [ADC_W-1:0]  I_CC1_SAMPLE,
	input  wire logic [ADC_W-1:0]  I_CC2_SAMPLE,
	input  wire logic [ADC_W-1:0]  I_PROFILE_SAMPLE,
	input  wire logic [ADC_W-1:0]  I_VBUS_SENSE,
	input  wire logic              I_PSEL,
	input  wire logic              I_PENABLE,
	input  wire logic              I_PWRITE,
	input  wire logic [7:0]        I_PADDR,
	input  wire logic [31:0]       I_PWDATA,
	output logic [31:0]            O_PRDATA,
	output logic                   O_PREADY,
	output logic                   O_PSLVERR,
	output logic                   O_VBUS_SUPPLY_EN,
	output logic                   O_AUDIO_ADAPTER,
	output logic                   O_FAULT_LATCHED_OUT,
	output logic                   O_PLUG_ORIENT_OE,
	output logic                   O_CC1_CABLE_POWER_OE,
	output logic                   O_CC2_CABLE_POWER_OE,
	output logic                   O_ATTACH_OE,
	output logic                   O_DEFAULT_CURRENT_OE,
	output logic                   O_MEDIUM_CURRENT_OE,
	output logic                   O_HIGH_CURRENT_OE
);

	//----------------------------------------
	// helpers
	//----------------------------------------
	function automatic logic [ADC_W-1:0] mv_code(input int mv);
		int c;
		c = (mv * ADC_STEPS) / ADC_FS_MV;
		if (c > ADC_STEPS - 1) begin
			c = ADC_STEPS - 1;
		end
		return c[ADC_W-1:0];
	endfunction

	function automatic logic in_win(input logic [ADC_W-1:0] v, input int lo_mv, input int hi_mv);
		return (v >= mv_code(lo_mv)) && (v <= mv_code(hi_mv));
	endfunction

	function automatic ccpoc_src_cc_t src_class(input logic [ADC_W-1:0] v, input ccpoc_prof_t p);
		logic rd;
		logic ra;
		rd = 1'b0;
		ra = 1'b0;
		case (p)
			PROF_HIGH: begin
				rd = in_win(v, SRC_HIGH_RD_LO_MV, SRC_HIGH_RD_HI_MV);
				ra = v <= mv_code(SRC_HIGH_RA_HI_MV);
			end
			PROF_MED: begin
				rd = in_win(v, SRC_MED_RD_LO_MV, SRC_MED_RD_HI_MV);
				ra = v <= mv_code(SRC_MED_RA_HI_MV);
			end
			PROF_DEF: begin
				rd = in_win(v, SRC_DEF_RD_LO_MV, SRC_DEF_RD_HI_MV);
				ra = v <= mv_code(SRC_DEF_RA_HI_MV);
			end
			default: begin
				rd = 1'b0;
				ra = 1'b0;
			end
		endcase
		return rd ? CC_RD : (ra ? CC_RA : CC_OPEN);
	endfunction

	function automatic ccpoc_snk_cc_t snk_class(input logic [ADC_W-1:0] v);
		if (v > mv_code(SNK_HIGH_LO_MV)) begin
			return SNK_HIGH;
		end else if (v >= mv_code(SNK_MED_LO_MV)) begin
			return SNK_MED;
		end else if (v >= mv_code(SNK_DEF_LO_MV)) begin
			return SNK_DEF;
		end
		return SNK_NONE;
	endfunction

	function automatic ccpoc_prof_t cfg_profile(input logic [ADC_W-1:0] v);
		if (in_win(v, CFG_HIGH_LO_MV, CFG_HIGH_HI_MV)) begin
			return PROF_HIGH;
		end else if (in_win(v, CFG_MED_LO_MV, CFG_MED_HI_MV)) begin
			return PROF_MED;
		end else if (v <= mv_code(CFG_DEF_HI_MV)) begin
			return PROF_DEF;
		end
		return PROF_NONE;
	endfunction

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction

	//----------------------------------------
	// state
	//----------------------------------------
	typedef struct packed {
		ccpoc_mode_t mode;
		ccpoc_prof_t profile;
		logic [1:0]  cc1_cls;
		logic [1:0]  cc2_cls;
		logic        en_prev;
		logic        sw_en;
		logic        fault_flag;
		logic        oc_seen;
		logic        ov_seen;
		logic        active;
		ccpoc_out_t  out;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} ccpoc_state_t;

	ccpoc_state_t st_reg;
	ccpoc_state_t st_next;

	logic oc_now;
	logic ov_now;
	logic fault_now;
	logic en_toggle;
	logic port_on;
	logic apb_wr;
	logic vbus_ok;

	assign oc_now    = !I_OVERCURRENT_IN_N;
	assign ov_now    = I_VBUS_SENSE > mv_code(VBUS_SENSE_OV_MV);
	assign fault_now = oc_now || ov_now;
	assign en_toggle = I_ENABLE != st_reg.en_prev;
	assign port_on   = I_ENABLE && st_reg.sw_en && !fault_now;
	assign apb_wr    = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
	assign vbus_ok   = in_win(I_VBUS_SENSE, VBUS_SENSE_VALID_LO_MV, VBUS_SENSE_OV_MV);

	//----------------------------------------
	// next state
	//----------------------------------------
	always_comb begin
		ccpoc_status_t sts;
		ccpoc_snk_cc_t snk_best;
		st_next = st_reg;
		sts     = '0;
		snk_best = SNK_NONE;
		st_next.en_prev = I_ENABLE;
		st_next.out     = '0;

		// strap caught on the first edge after reset; sink is then kept for good
		if (st_reg.mode == MODE_UNSET) begin
			st_next.mode = (I_PROFILE_SAMPLE >= mv_code(CFG_SINK_LO_MV)) ? MODE_SNK : MODE_SRC;
		end
		if (st_reg.mode == MODE_SRC) begin
			st_next.profile = cfg_profile(I_PROFILE_SAMPLE);
		end

		// both lines classified on every cycle
		if (st_reg.mode == MODE_SNK) begin
			st_next.cc1_cls = 2'(snk_class(I_CC1_SAMPLE));
			st_next.cc2_cls = 2'(snk_class(I_CC2_SAMPLE));
		end else begin
			st_next.cc1_cls = 2'(src_class(I_CC1_SAMPLE, st_reg.profile));
			st_next.cc2_cls = 2'(src_class(I_CC2_SAMPLE, st_reg.profile));
		end

		// sticky fault: an event in the toggle cycle wins over the clear
		if (en_toggle) begin
			st_next.fault_flag = 1'b0;
			st_next.oc_seen    = 1'b0;
			st_next.ov_seen    = 1'b0;
		end
		if (oc_now) begin
			st_next.fault_flag = 1'b1;
			st_next.oc_seen    = 1'b1;
		end
		if (ov_now) begin
			st_next.fault_flag = 1'b1;
			st_next.ov_seen    = 1'b1;
		end
		st_next.out.fault_latched_out = st_next.fault_flag;

		// outputs stay at defaults when disabled or faulted
		st_next.active = port_on;
		if (port_on && st_reg.mode == MODE_SRC && st_reg.profile != PROF_NONE) begin
			if (st_reg.cc1_cls == 2'(CC_RD)) begin
				st_next.out.vbus_supply_en     = 1'b1;
				st_next.out.cc2_cable_power_oe = st_reg.cc2_cls == 2'(CC_RA);
			end else if (st_reg.cc2_cls == 2'(CC_RD)) begin
				st_next.out.vbus_supply_en     = 1'b1;
				st_next.out.orient_oe          = 1'b1;
				st_next.out.cc1_cable_power_oe = st_reg.cc1_cls == 2'(CC_RA);
			end else if (st_reg.cc1_cls == 2'(CC_RA) && st_reg.cc2_cls == 2'(CC_RA)) begin
				// switch outside selects audio while this is high
				st_next.out.audio_adapter = 1'b1;
			end
			// anything else is detach: all source outputs stay cleared
		end else if (port_on && st_reg.mode == MODE_SNK) begin
			snk_best = ccpoc_snk_cc_t'((st_reg.cc1_cls > st_reg.cc2_cls) ? st_reg.cc1_cls : st_reg.cc2_cls);
			if (snk_best != SNK_NONE && vbus_ok) begin
				st_next.out.attach_oe = 1'b1;
				// one indicator only, picked from the stronger line
				st_next.out.default_current_oe = snk_best == SNK_DEF;
				st_next.out.medium_current_oe  = snk_best == SNK_MED;
				st_next.out.high_current_oe    = snk_best == SNK_HIGH;
			end
		end

		// apb: data set up in the setup cycle, answer one cycle later
		if (apb_wr && reg_hit(I_PADDR, REG_CTRL_OFS)) begin
			st_next.sw_en = I_PWDATA[CTRL_SW_EN_BIT];
		end
		sts.mode       = st_reg.mode;
		sts.profile    = st_reg.profile;
		sts.cc1_cls    = st_reg.cc1_cls;
		sts.cc2_cls    = st_reg.cc2_cls;
		sts.fault_flag = st_reg.fault_flag;
		sts.oc_seen    = st_reg.oc_seen;
		sts.ov_seen    = st_reg.ov_seen;
		sts.active     = st_reg.active;
		st_next.pready  = I_PSEL && !I_PENABLE;
		st_next.pslverr = 1'b0;
		st_next.prdata  = '0;
		if (I_PSEL && !I_PENABLE) begin
			if (reg_hit(I_PADDR, REG_CTRL_OFS)) begin
				st_next.prdata = {31'h0000_0000, st_reg.sw_en};
			end else if (reg_hit(I_PADDR, REG_STATUS_OFS)) begin
				st_next.prdata = sts;
			end else if (reg_hit(I_PADDR, REG_ID_OFS)) begin
				st_next.prdata = BLOCK_ID_VAL;
			end else begin
				st_next.pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			st_reg         <= '0;
			st_reg.mode    <= MODE_UNSET;
			st_reg.profile <= PROF_NONE;
			st_reg.sw_en   <= CTRL_SW_EN_RST;
			// enable idles high: no false toggle right after reset
			st_reg.en_prev <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign O_PRDATA             = st_reg.prdata;
	assign O_PREADY             = st_reg.pready;
	assign O_PSLVERR            = st_reg.pslverr;
	assign O_VBUS_SUPPLY_EN     = st_reg.out.vbus_supply_en;
	assign O_AUDIO_ADAPTER      = st_reg.out.audio_adapter;
	assign O_FAULT_LATCHED_OUT  = st_reg.out.fault_latched_out;
	assign O_PLUG_ORIENT_OE     = st_reg.out.orient_oe;
	assign O_CC1_CABLE_POWER_OE = st_reg.out.cc1_cable_power_oe;
	assign O_CC2_CABLE_POWER_OE = st_reg.out.cc2_cable_power_oe;
	assign O_ATTACH_OE          = st_reg.out.attach_oe;
	assign O_DEFAULT_CURRENT_OE = st_reg.out.default_current_oe;
	assign O_MEDIUM_CURRENT_OE  = st_reg.out.medium_current_oe;
	assign O_HIGH_CURRENT_OE    = st_reg.out.high_current_oe;

	//----------------------------------------
	// checks
	//----------------------------------------
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RESET);

	logic src_live;
	logic any_port_out;
	assign src_live     = port_on && st_reg.mode == MODE_SRC && st_reg.profile != PROF_NONE;
	assign any_port_out = |(st_reg.out & ~ccpoc_out_t'(10'b0010000000));

	sequence s_fault_event;
		!I_OVERCURRENT_IN_N || ov_now;
	endsequence
	sequence s_quiet_enable;
		!en_toggle && !fault_now;
	endsequence

	a_vbus_on_rd: assert property (src_live && st_reg.cc1_cls == 2'(CC_RD) |=> O_VBUS_SUPPLY_EN)
		else $error("vbus enable missing with sink on cc1");
	a_orient_idle: assert property (st_reg.cc2_cls != 2'(CC_RD) || st_reg.cc1_cls == 2'(CC_RD)
		|=> !O_PLUG_ORIENT_OE)
		else $error("orientation pulled low without cc2 sink");
	a_orient_flip: assert property (src_live && st_reg.cc1_cls != 2'(CC_RD) && st_reg.cc2_cls == 2'(CC_RD)
		|=> O_PLUG_ORIENT_OE && O_VBUS_SUPPLY_EN)
		else $error("flipped plug not flagged");
	a_cable_cc1: assert property (src_live && st_reg.cc2_cls == 2'(CC_RD) && st_reg.cc1_cls == 2'(CC_RA)
		|=> O_CC1_CABLE_POWER_OE && !O_CC2_CABLE_POWER_OE)
		else $error("cc1 cable power wrong");
	a_cable_cc2: assert property (src_live && st_reg.cc1_cls == 2'(CC_RD) && st_reg.cc2_cls == 2'(CC_RA)
		|=> O_CC2_CABLE_POWER_OE && !O_CC1_CABLE_POWER_OE)
		else $error("cc2 cable power wrong");
	a_audio_flag: assert property (src_live && st_reg.cc1_cls == 2'(CC_RA) && st_reg.cc2_cls == 2'(CC_RA)
		|=> O_AUDIO_ADAPTER && !O_VBUS_SUPPLY_EN)
		else $error("audio adapter not flagged");
	a_fault_sets: assert property (s_fault_event
		|=> O_FAULT_LATCHED_OUT ##1 (O_FAULT_LATCHED_OUT || $past(en_toggle)))
		else $error("fault indicator not latched");
	a_fault_holds: assert property (O_FAULT_LATCHED_OUT ##0 s_quiet_enable |=> O_FAULT_LATCHED_OUT)
		else $error("fault indicator dropped without enable toggle");
	a_fault_clear: assert property (O_FAULT_LATCHED_OUT && en_toggle && !fault_now |=> !O_FAULT_LATCHED_OUT)
		else $error("enable toggle did not clear fault");
	a_sink_attach: assert property (O_ATTACH_OE |-> $past(vbus_ok) && st_reg.mode == MODE_SNK)
		else $error("attach without valid vbus");
	a_one_level: assert property ($onehot0({O_DEFAULT_CURRENT_OE, O_MEDIUM_CURRENT_OE, O_HIGH_CURRENT_OE})
		&& (O_ATTACH_OE || !(O_DEFAULT_CURRENT_OE || O_MEDIUM_CURRENT_OE || O_HIGH_CURRENT_OE)))
		else $error("current indicators not exclusive");
	a_fault_quiet: assert property (fault_now |=> !any_port_out [*1])
		else $error("outputs active during fault");
	a_disable_quiet: assert property (!I_ENABLE [*2] |-> ##1 !any_port_out && !st_reg.active)
		else $error("outputs active while disabled");
	a_sink_kept: assert property (st_reg.mode == MODE_SNK |=> st_reg.mode == MODE_SNK)
		else $error("sink mode lost");
	a_ov_latch: assert property (ov_now |=> O_FAULT_LATCHED_OUT && !O_VBUS_SUPPLY_EN)
		else $error("overvoltage not latched");
	a_detach_clear: assert property (st_reg.mode == MODE_SRC && st_reg.cc1_cls == 2'(CC_OPEN)
		&& st_reg.cc2_cls == 2'(CC_OPEN) |=> !O_VBUS_SUPPLY_EN && !O_AUDIO_ADAPTER
		&& !O_CC1_CABLE_POWER_OE && !O_CC2_CABLE_POWER_OE)
		else $error("source outputs left on after detach");

endmodule

// ---- hdl/ccpoc_pkg.sv ----
// constants, types and register map of the cc port output control block
// assumes 8-bit converter samples of 0..5000 mV, taken synchronously to the core clock
package ccpoc_pkg;

	//----------------------------------------
	// converter scaling
	//----------------------------------------
	localparam int ADC_W       = 8;
	localparam int ADC_FS_MV   = 5000;
	localparam int ADC_STEPS   = 256;

	//----------------------------------------
	// profile strap windows, mV
	//----------------------------------------
	localparam int CFG_HIGH_LO_MV   = 1200;
	localparam int CFG_HIGH_HI_MV   = 1300;
	localparam int CFG_MED_LO_MV    = 700;
	localparam int CFG_MED_HI_MV    = 800;
	localparam int CFG_DEF_HI_MV    = 300;
	localparam int CFG_SINK_LO_MV   = 1750;

	//----------------------------------------
	// source side cc windows, mV (per profile)
	//----------------------------------------
	localparam int SRC_HIGH_RD_HI_MV = 2600;
	localparam int SRC_HIGH_RD_LO_MV = 850;
	localparam int SRC_HIGH_RA_HI_MV = 800;
	localparam int SRC_MED_RD_HI_MV  = 1600;
	localparam int SRC_MED_RD_LO_MV  = 450;
	localparam int SRC_MED_RA_HI_MV  = 400;
	localparam int SRC_DEF_RD_HI_MV  = 1600;
	localparam int SRC_DEF_RD_LO_MV  = 250;
	localparam int SRC_DEF_RA_HI_MV  = 200;

	//----------------------------------------
	// sink side cc windows and vbus monitor, mV
	//----------------------------------------
	localparam int SNK_DEF_LO_MV     = 250;
	localparam int SNK_MED_LO_MV     = 700;
	localparam int SNK_HIGH_LO_MV    = 1310;
	localparam int VBUS_SENSE_OV_MV        = 800;
	localparam int VBUS_SENSE_VALID_LO_MV  = 500;

	//----------------------------------------
	// apb register map
	//----------------------------------------
	localparam logic [7:0]  REG_CTRL_OFS    = 8'h00;
	localparam logic [7:0]  REG_STATUS_OFS  = 8'h04;
	localparam logic [7:0]  REG_ID_OFS      = 8'h08;
	localparam int          CTRL_SW_EN_BIT  = 0;
	localparam logic        CTRL_SW_EN_RST  = 1'b1;
	// arbitrary value
	localparam logic [31:0] BLOCK_ID_VAL    = 32'h0000_c0de;

	//----------------------------------------
	// types
	//----------------------------------------
	typedef enum logic [1:0] {MODE_UNSET, MODE_SRC, MODE_SNK}            ccpoc_mode_t;
	typedef enum logic [1:0] {PROF_NONE, PROF_DEF, PROF_MED, PROF_HIGH}  ccpoc_prof_t;
	typedef enum logic [1:0] {CC_OPEN, CC_RD, CC_RA}                     ccpoc_src_cc_t;
	typedef enum logic [1:0] {SNK_NONE, SNK_DEF, SNK_MED, SNK_HIGH}      ccpoc_snk_cc_t;

	typedef struct packed {
		logic [19:0] zero;
		logic        active;
		logic        ov_seen;
		logic        oc_seen;
		logic        fault_flag;
		logic [1:0]  cc2_cls;
		logic [1:0]  cc1_cls;
		logic [1:0]  profile;
		logic [1:0]  mode;
	} ccpoc_status_t;

	typedef struct packed {
		logic vbus_supply_en;
		logic audio_adapter;
		logic fault_latched_out;
		logic orient_oe;
		logic cc1_cable_power_oe;
		logic cc2_cable_power_oe;
		logic attach_oe;
		logic default_current_oe;
		logic medium_current_oe;
		logic high_current_oe;
	} ccpoc_out_t;

endpackage

// ---- sim/ccpoc_cable_model.sv ----
// behavioural cable and partner port at the cc connector, plus the outside audio switch
// assumes it is clocked by the core clock and that the bench picks the attach pattern
module ccpoc_cable_model
	import ccpoc_pkg::*;
(
	input  wire logic             i_clk,
	input  wire logic             i_far_source,
	input  wire logic [1:0]       i_cc1_load,
	input  wire logic [1:0]       i_cc2_load,
	input  wire logic [1:0]       i_vbus_state,
	input  wire logic             i_audio_adapter,
	output logic      [ADC_W-1:0] o_cc1,
	output logic      [ADC_W-1:0] o_cc2,
	output logic      [ADC_W-1:0] o_vbus,
	output logic                  o_audio_path
);
	timeunit 1ns;
	timeprecision 1ps;

	//----------------------------------------
	// line levels, converter codes
	//----------------------------------------
	function automatic logic [ADC_W-1:0] code(input int mv);
		return ADC_W'(mv * ADC_STEPS / ADC_FS_MV);
	endfunction

	function automatic logic [ADC_W-1:0] line(input logic [1:0] ld);
		if (i_far_source) begin
			case (ld)
				2'd0:    return code(100);
				2'd1:    return code(500);
				2'd2:    return code(1000);
				default: return code(2000);
			endcase
		end
		// open line floats up, sink pull-down, cable pull-down
		case (ld)
			2'd1:    return code(1000);
			2'd2:    return code(100);
			default: return code(4900);
		endcase
	endfunction

	always @(posedge i_clk) begin
		o_cc1  <= line(i_cc1_load);
		o_cc2  <= line(i_cc2_load);
		o_vbus <= (i_vbus_state == 2'd2) ? code(1000) : (i_vbus_state == 2'd1) ? code(650) : 8'h00;
	end

	// high selects audio signalling, low the usb data pair
	assign o_audio_path = i_audio_adapter;
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench of the cc port output control block
// assumes the cable model on the cc lines and an apb master made of tasks here
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
	$display("MISMATCH at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top
	import ccpoc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic             enable = 1'b1;
	logic             oc_n = 1'b1;
	logic [ADC_W-1:0] strap = 8'h00;
	logic             far_src = 1'b0;
	logic [1:0]       ld1 = 2'd0;
	logic [1:0]       ld2 = 2'd0;
	logic [1:0]       vb = 2'd0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [7:0]       paddr = 8'h00;
	logic [31:0]      pwdata = 32'h0;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic [ADC_W-1:0] cc1;
	logic [ADC_W-1:0] cc2;
	logic [ADC_W-1:0] vsense;
	logic [9:0]       outs;
	logic             audio_path;
	logic [31:0]      rd;
	logic             err;
	int               mismatches = 0;
	int               n_tests = 0;

	initial begin
		forever #5 clk = ~clk;
	end

	ccpoc_port_ctrl i_ccpoc_port_ctrl (
		.I_CORE_CLK(clk), .I_RESET(rst), .I_ENABLE(enable), .I_OVERCURRENT_IN_N(oc_n),
		.I_CC1_SAMPLE(cc1), .I_CC2_SAMPLE(cc2), .I_PROFILE_SAMPLE(strap), .I_VBUS_SENSE(vsense),
		.I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.O_VBUS_SUPPLY_EN(outs[9]), .O_AUDIO_ADAPTER(outs[8]), .O_FAULT_LATCHED_OUT(outs[7]),
		.O_PLUG_ORIENT_OE(outs[6]), .O_CC1_CABLE_POWER_OE(outs[5]), .O_CC2_CABLE_POWER_OE(outs[4]),
		.O_ATTACH_OE(outs[3]), .O_DEFAULT_CURRENT_OE(outs[2]), .O_MEDIUM_CURRENT_OE(outs[1]),
		.O_HIGH_CURRENT_OE(outs[0]));

	ccpoc_cable_model i_ccpoc_cable_model (
		.i_clk(clk), .i_far_source(far_src), .i_cc1_load(ld1), .i_cc2_load(ld2), .i_vbus_state(vb),
		.i_audio_adapter(outs[8]), .o_cc1(cc1), .o_cc2(cc2), .o_vbus(vsense), .o_audio_path(audio_path));

	//----------------------------------------
	// helpers
	//----------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd; penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	task automatic settle();
		repeat (6) @(posedge clk);
	endtask

	task automatic attach(input logic [1:0] a, input logic [1:0] b, input logic [9:0] e);
		ld1 <= a; ld2 <= b;
		settle();
		`CHK(outs, e)
	endtask

	task automatic do_reset(input logic [ADC_W-1:0] s);
		strap <= s; rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		settle();
	endtask

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#400000;
		mismatches++;
		complete_run();
	end

	//----------------------------------------
	// tests
	//----------------------------------------
	initial begin
		do_reset(8'h00);
		apb(1'b0, REG_ID_OFS, 32'h0);
		`CHK(rd, BLOCK_ID_VAL)
		apb(1'b1, 8'h0c, 32'h0);
		`CHK(err, 1'b1)
		apb(1'b0, REG_CTRL_OFS, 32'h0);
		`CHK(rd, 32'h1)
		$display("test registers done");

		attach(2'd0, 2'd0, 10'h000);
		attach(2'd1, 2'd0, 10'h200);
		apb(1'b0, REG_STATUS_OFS, 32'h0);
		`CHK(rd[7:0], 8'h15)
		attach(2'd1, 2'd2, 10'h210);
		attach(2'd2, 2'd1, 10'h260);
		attach(2'd2, 2'd2, 10'h100);
		`CHK(audio_path, 1'b1)
		attach(2'd0, 2'd0, 10'h000);
		attach(2'd1, 2'd0, 10'h200);
		apb(1'b1, REG_CTRL_OFS, 32'h0);
		settle();
		`CHK(outs, 10'h000)
		apb(1'b1, REG_CTRL_OFS, 32'h1);
		enable <= 1'b0;
		settle();
		`CHK(outs, 10'h000)
		enable <= 1'b1;
		settle();
		`CHK(outs, 10'h200)
		$display("test source done");

		strap <= 8'h40;
		settle();
		apb(1'b0, REG_STATUS_OFS, 32'h0);
		`CHK(rd[3:0], 4'hd)
		`CHK(outs, 10'h200)
		strap <= 8'h26;
		settle();
		apb(1'b0, REG_STATUS_OFS, 32'h0);
		`CHK(rd[3:0], 4'h9)
		strap <= 8'h30;
		settle();
		`CHK(outs, 10'h000)
		strap <= 8'h00;
		settle();
		`CHK(outs, 10'h200)
		$display("test profile done");

		oc_n <= 1'b0;
		settle();
		`CHK(outs, 10'h080)
		oc_n <= 1'b1;
		settle();
		`CHK(outs, 10'h280)
		do_reset(8'h00);
		`CHK(outs, 10'h200)
		enable <= 1'b0;
		@(posedge clk);
		enable <= 1'b1;
		settle();
		`CHK(outs, 10'h200)
		vb <= 2'd2;
		settle();
		`CHK(outs, 10'h080)
		vb <= 2'd0;
		settle();
		`CHK(outs[7], 1'b1)
		enable <= 1'b0;
		@(posedge clk);
		enable <= 1'b1;
		settle();
		`CHK(outs, 10'h200)
		$display("test fault done");

		far_src <= 1'b1;
		ld1 <= 2'd0;
		do_reset(8'hff);
		strap <= 8'h00;
		vb <= 2'd1;
		attach(2'd1, 2'd0, 10'h00c);
		attach(2'd0, 2'd2, 10'h00a);
		attach(2'd3, 2'd1, 10'h009);
		apb(1'b0, REG_STATUS_OFS, 32'h0);
		`CHK(rd[1:0], 2'd2)
		vb <= 2'd0;
		settle();
		`CHK(outs, 10'h000)
		vb <= 2'd1;
		attach(2'd0, 2'd0, 10'h000);
		$display("test sink done");
		complete_run();
	end
endmodule
